// ===== rtl/ledhp_top.sv
// module: host write port, display ram and digit scan of an eight digit led driver
// What this block does
// [R1] rising write strobe captures the eight data inputs into control word or ram
// [R2] select high loads control word, low loads display ram
// [R3] control bit 6 high picks hex font, low picks alternate bcd font
// [R4] control bit 5 high picks raw segment mode, low decoded mode
// [R5] control bit 7 high announces a burst load of display data
// [R6] control bit 4 high runs normally, low stops scan and blanks display
// [R7] with burst low, control bits 2..0 address the single digit to update
// [R8] in decoded formats control bit 3 high picks bank a, low bank b
// [R9] ram writes take data bits 0..7, bit 7 is the decimal point
// [R10] direct variant: digit select pins address the digit written per strobe
// [R11] direct variant: decimal point input is active low, low lights it
// [R12] direct variant: function pin high hex, float bcd, low shutdown
// [R13] host drives register select from address line a0, two locations
// [R14] host pulses strobe only for accesses aimed at this device
// [R15] host writes a control word before any display data
// [R16] display ram holds two independent banks for decoded data
// [R17] bank select only in decoded formats; raw data uses both banks
// [R18] decimal point stored per digit, independent of bank
// [R19] control word without burst leaves ram unchanged, bank picks shown bank
// [R20] burst: blank, write next 8 strobes to digits 1..8, unblank, ignore more
// [R21] single digit mode writes data only to the addressed digit
// [R22] raw mode: high lights a segment, but low lights the decimal point
// [R23] scan eight digits cyclically, one digit line at a time
`timescale 1ns/10ps
module ledhp_top #(
  parameter bit DIRECT_VARIANT = 1'b0,
  parameter int SCAN_COUNT     = ledhp_pkg::SCAN_CYCLES
) (
  // clock and reset
  input  wire logic                             SYS_CLK,
  input  wire logic                             RST,
  // host write port
  input  wire logic [ledhp_pkg::DATA_W-1:0]     HOST_DATA,
  input  wire logic                             REG_SEL,
  input  wire logic                             WRITE_STROBE,
  // direct variant pins
  input  wire logic [ledhp_pkg::ADDR_W-1:0]     DIGIT_SEL,
  input  wire ledhp_pkg::ledhp_fn_t             FUNCTION_PIN,
  // led drive lines
  output logic      [ledhp_pkg::DIGITS-1:0]     DIGIT_EN,
  output logic      [ledhp_pkg::SEG_W-1:0]      SEG_OUT
);
  import ledhp_pkg::*;

  localparam int CNT_W = $clog2(SCAN_COUNT + 1);
  localparam logic [CNT_W-1:0]  CNT_LAST  = CNT_W'(SCAN_COUNT - 1);
  localparam logic [ADDR_W-1:0] ADDR_LAST = ADDR_W'(DIGITS - 1);
  // idle level of the host pins: the strobe rests high, so a low reset value would fake a write
  localparam ledhp_host_t       PIN_IDLE  = '{data: '0, reg_sel: 1'b0, strobe: 1'b1, digit_sel: '0};

  // ==========================================================================
  // pin synchronisers, two flops before any logic
  // trade-off: two cycles of latency for safety; the host holds every level longer than that
  ledhp_host_t pin_s1_r, pin_s2_r, pin_s3_r;
  ledhp_fn_t   fn_s1_r, fn_s2_r;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pin_s1_r <= PIN_IDLE;
      pin_s2_r <= PIN_IDLE;
      pin_s3_r <= PIN_IDLE;
      fn_s1_r  <= LEDHP_FN_HIGH;
      fn_s2_r  <= LEDHP_FN_HIGH;
    end else begin
      pin_s1_r <= '{data: HOST_DATA, reg_sel: REG_SEL, strobe: WRITE_STROBE, digit_sel: DIGIT_SEL};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;       // previous synced sample for edge detect
      fn_s1_r  <= FUNCTION_PIN;
      fn_s2_r  <= fn_s1_r;
    end
  end

  // rising strobe; data and select are sampled with the same delay so they line up
  // data and select are read only at the strobe edge, so skew between their flops does no harm
  logic wr_rise;
  assign wr_rise = pin_s2_r.strobe & ~pin_s3_r.strobe;   // [R1]

  // ==========================================================================
  // control word decode
  // one decoder serves both the stored word and the word being written
  function automatic ledhp_ctrl_t decode_cw(input logic [DATA_W-1:0] w);
    ledhp_ctrl_t c;
    c.burst    = w[CW_BURST];
    c.font_hex = w[CW_FONT];
    c.raw_mode = w[CW_FORMAT];
    c.power_on = w[CW_POWER];
    c.bank_a   = w[CW_BANK];
    c.addr     = w[CW_ADDR_LO +: ADDR_W];
    return c;
  endfunction : decode_cw

  // ==========================================================================
  // control and burst state
  // idle: no control word yet, ram writes are dropped
  // single: ram writes go to the one addressed digit
  // burst: eight writes fill the digits in order while the display is blanked
  // done: burst finished, further ram writes are dropped
  typedef enum logic [1:0] {LEDHP_IDLE, LEDHP_SINGLE, LEDHP_BURST, LEDHP_DONE} ledhp_state_t;

  logic [DATA_W-1:0] cw_r, cw_nxt;
  ledhp_state_t      state_r, state_nxt;
  logic [ADDR_W-1:0] waddr_r, waddr_nxt;
  logic              ram_we;
  logic [ADDR_W-1:0] ram_addr;
  ledhp_ctrl_t       ctrl;
  ledhp_ctrl_t       wr_cw;
  assign ctrl = decode_cw(cw_r);
  // settings carried by the word now being written, used only on a control strobe
  assign wr_cw = decode_cw(pin_s2_r.data);

  // next control state from each captured strobe
  always_comb begin
    cw_nxt    = cw_r;
    state_nxt = state_r;
    waddr_nxt = waddr_r;
    ram_we    = 1'b0;
    ram_addr  = waddr_r;
    if (DIRECT_VARIANT) begin
      if (wr_rise) begin
        ram_we   = 1'b1;                         // [R10]
        ram_addr = pin_s2_r.digit_sel;           // [R10]
      end
    end else if (wr_rise) begin
      if (pin_s2_r.reg_sel) begin
        // a new control word always wins, even in the middle of a burst
        cw_nxt    = pin_s2_r.data;               // [R2] [R19] no ram write here
        waddr_nxt = wr_cw.burst ? '0 : wr_cw.addr;               // [R7]
        state_nxt = wr_cw.burst ? LEDHP_BURST : LEDHP_SINGLE;    // [R5]
      end else begin
        case (state_r)
          LEDHP_SINGLE: begin
            ram_we = 1'b1;                       // [R21]
          end
          LEDHP_BURST: begin
            ram_we    = 1'b1;                    // [R20]
            // wraps to zero after the last digit; the done state keeps that from being used
            waddr_nxt = waddr_r + ADDR_W'(1);
            if (waddr_r == ADDR_LAST) begin
              state_nxt = LEDHP_DONE;            // [R20] extra strobes ignored
            end
          end
          default: ram_we = 1'b0;                // no control word yet, or burst done [R15]
        endcase
      end
    end
  end

  // control word, write state and write address registers
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cw_r    <= CW_RESET;
      state_r <= LEDHP_IDLE;
      waddr_r <= '0;
    end else begin
      cw_r    <= cw_nxt;
      state_r <= state_nxt;
      waddr_r <= waddr_nxt;
    end
  end

  // ==========================================================================
  // display ram: low nibble per bank, upper three bits shared, dp per digit
  // the decimal point lives outside the banks, so a bank swap never moves it
  // a raw byte spreads over both nibbles, so a raw write spoils both decoded banks
  logic [3:0] bank_a_r [DIGITS], bank_a_nxt [DIGITS];
  logic [3:0] bank_b_r [DIGITS], bank_b_nxt [DIGITS];
  logic [2:0] upper_r  [DIGITS], upper_nxt  [DIGITS];
  logic       dp_r     [DIGITS], dp_nxt     [DIGITS];

  // raw mode fills bank a with the low nibble and bank b with the upper bits
  genvar gi;
  generate
    for (gi = 0; gi < DIGITS; gi++) begin : g_ram
      always_comb begin
        bank_a_nxt[gi] = bank_a_r[gi];
        bank_b_nxt[gi] = bank_b_r[gi];
        upper_nxt[gi]  = upper_r[gi];
        dp_nxt[gi]     = dp_r[gi];
        if (ram_we && ram_addr == ADDR_W'(gi)) begin
          dp_nxt[gi] = pin_s2_r.data[DATA_DP];         // [R9] [R11] [R18] stored as written
          if (DIRECT_VARIANT || !ctrl.raw_mode) begin
            if (DIRECT_VARIANT || ctrl.bank_a) begin
              bank_a_nxt[gi] = pin_s2_r.data[3:0];     // [R8] [R16]
            end else begin
              bank_b_nxt[gi] = pin_s2_r.data[3:0];     // [R8] [R16]
            end
          end else begin
            bank_a_nxt[gi] = pin_s2_r.data[3:0];       // [R17] raw uses both banks
            bank_b_nxt[gi] = {1'b0, pin_s2_r.data[6:4]};
            upper_nxt[gi]  = pin_s2_r.data[6:4];
          end
        end
      end
      // ram cells; the decimal point starts unlit
      always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
          bank_a_r[gi] <= '0;
          bank_b_r[gi] <= '0;
          upper_r[gi]  <= '0;
          dp_r[gi]     <= 1'b1;                        // dp off
        end else begin
          bank_a_r[gi] <= bank_a_nxt[gi];
          bank_b_r[gi] <= bank_b_nxt[gi];
          upper_r[gi]  <= upper_nxt[gi];
          dp_r[gi]     <= dp_nxt[gi];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // effective mode: direct variant follows the three-level pin
  // the direct variant has no control word, so its mode comes from the pin alone
  logic eff_power, eff_hex, eff_raw, eff_bank_a, blank;
  always_comb begin
    if (DIRECT_VARIANT) begin
      eff_power  = (fn_s2_r != LEDHP_FN_LOW);         // [R12]
      eff_hex    = (fn_s2_r == LEDHP_FN_HIGH);        // [R12]
      eff_raw    = 1'b0;
      eff_bank_a = 1'b1;
    end else begin
      eff_power  = ctrl.power_on;                     // [R6]
      eff_hex    = ctrl.font_hex;                     // [R3]
      eff_raw    = ctrl.raw_mode;                     // [R4]
      eff_bank_a = ctrl.bank_a;                       // [R19] bank shown on all digits
    end
  end
  // display blanked while a burst is loading
  // the scan keeps running during a burst, so the digit shown after it need not be digit 1
  assign blank = ~eff_power | (state_r == LEDHP_BURST);  // [R20] [R6]

  // ==========================================================================
  // scan counter and digit pointer, halted in shutdown
  // limitation: the count halts mid-digit, so the first dwell after wake-up is short
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  logic [ADDR_W-1:0] scan_r, scan_nxt;
  always_comb begin
    cnt_nxt  = cnt_r;
    scan_nxt = scan_r;
    if (eff_power) begin
      if (cnt_r == CNT_LAST) begin
        cnt_nxt  = '0;
        scan_nxt = scan_r + ADDR_W'(1);                // [R23]
      end else begin
        cnt_nxt = cnt_r + CNT_W'(1);
      end
    end
  end

  // segment pattern for the digit under scan
  // digit line and segments leave the same edge, so no old pattern ghosts onto the new digit
  logic [6:0]       dec_segs;
  logic [SEG_W-1:0] seg_nxt;
  logic [DIGITS-1:0] dig_nxt;
  logic [3:0]       shown_code;
  logic [6:0]       raw_bits;
  assign shown_code = eff_bank_a ? bank_a_r[scan_r] : bank_b_r[scan_r];
  assign raw_bits   = {upper_r[scan_r], bank_a_r[scan_r]};

  ledhp_seg_decode u_dec (
    .code     (shown_code),
    .font_hex (eff_hex),
    .segs     (dec_segs)
  );

  always_comb begin
    seg_nxt = SEG_OFF;
    dig_nxt = DIG_OFF;
    if (!blank) begin
      dig_nxt[scan_r] = 1'b1;                          // [R23] one digit at a time
      if (eff_raw) begin
        seg_nxt[SEG_A] = raw_bits[RAW_A];              // [R22]
        seg_nxt[SEG_B] = raw_bits[RAW_B];
        seg_nxt[SEG_C] = raw_bits[RAW_C];
        seg_nxt[SEG_D] = raw_bits[RAW_D];
        seg_nxt[SEG_E] = raw_bits[RAW_E];
        seg_nxt[SEG_F] = raw_bits[RAW_F];
        seg_nxt[SEG_G] = raw_bits[RAW_G];
      end else begin
        seg_nxt[SEG_G:SEG_A] = dec_segs;
      end
      seg_nxt[SEG_DP] = ~dp_r[scan_r];                 // [R22] [R11] low lights dp
    end
  end

  // registered drive lines
  // straight from flops, so the drive lines never glitch between edges
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cnt_r    <= '0;
      scan_r   <= '0;
      DIGIT_EN <= DIG_OFF;
      SEG_OUT  <= SEG_OFF;
    end else begin
      cnt_r    <= cnt_nxt;
      scan_r   <= scan_nxt;
      DIGIT_EN <= dig_nxt;
      SEG_OUT  <= seg_nxt;
    end
  end

endmodule : ledhp_top

// ===== include/ledhp_pkg.sv
// package: constants, types and encodings of the led display host write port
package ledhp_pkg;

  // ==========================================================================
  // widths and counts
  localparam int DATA_W    = 8;
  localparam int DIGITS    = 8;
  localparam int ADDR_W    = 3;
  localparam int SEG_W     = 8;                // dp, a..g

  // ==========================================================================
  // control word bit positions
  localparam int CW_ADDR_LO  = 0;
  localparam int CW_BANK     = 3;
  localparam int CW_POWER    = 4;
  localparam int CW_FORMAT   = 5;
  localparam int CW_FONT     = 6;
  localparam int CW_BURST    = 7;
  localparam int DATA_DP     = 7;              // decimal point bit of display data

  // segment output bit positions
  localparam int SEG_A  = 0;
  localparam int SEG_B  = 1;
  localparam int SEG_C  = 2;
  localparam int SEG_D  = 3;
  localparam int SEG_E  = 4;
  localparam int SEG_F  = 5;
  localparam int SEG_G  = 6;
  localparam int SEG_DP = 7;

  // raw segment mode: data bit that drives each segment
  localparam int RAW_D = 0;
  localparam int RAW_F = 1;
  localparam int RAW_G = 2;
  localparam int RAW_E = 3;
  localparam int RAW_C = 4;
  localparam int RAW_B = 5;
  localparam int RAW_A = 6;

  // ==========================================================================
  // timing
  localparam int CLK_MHZ      = 100;
  localparam int SCAN_US      = 320;           // dwell per digit, ~390 Hz per digit over 8
  localparam int SCAN_CYCLES  = SCAN_US * CLK_MHZ;

  // reset values of the control word and the drive lines
  localparam logic [DATA_W-1:0] CW_RESET = 8'h10;      // powered, decoded, font b, bank b
  localparam logic [SEG_W-1:0]  SEG_OFF  = 8'h00;
  localparam logic [DIGITS-1:0] DIG_OFF  = 8'h00;

  // ==========================================================================
  // variant and three-level pin encodings
  typedef enum logic [1:0] {
    LEDHP_FN_LOW,                              // shutdown
    LEDHP_FN_FLOAT,                            // alternate bcd font
    LEDHP_FN_HIGH                              // hexadecimal font
  } ledhp_fn_t;

  // control settings decoded from the control word
  typedef struct packed {
    logic              burst;
    logic              font_hex;
    logic              raw_mode;
    logic              power_on;
    logic              bank_a;
    logic [ADDR_W-1:0] addr;
  } ledhp_ctrl_t;

  // host write port pins
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              reg_sel;
    logic              strobe;
    logic [ADDR_W-1:0] digit_sel;
  } ledhp_host_t;

endpackage : ledhp_pkg

// ===== rtl/ledhp_seg_decode.sv
// module: seven segment character decoder for hex and alternate bcd fonts
`timescale 1ns/10ps
module ledhp_seg_decode (
  // stored digit data
  input  wire logic [3:0]               code,
  input  wire logic                     font_hex,
  // segment pattern, a..g in bits 0..6
  output logic      [6:0]               segs
);
  import ledhp_pkg::*;

  // ==========================================================================
  // character lookup, gfedcba order
  always_comb begin
    segs = 7'h00;
    case (code)
      4'h0: segs = 7'h3f;
      4'h1: segs = 7'h06;
      4'h2: segs = 7'h5b;
      4'h3: segs = 7'h4f;
      4'h4: segs = 7'h66;
      4'h5: segs = 7'h6d;
      4'h6: segs = 7'h7d;
      4'h7: segs = 7'h07;
      4'h8: segs = 7'h7f;
      4'h9: segs = 7'h6f;
      4'ha: segs = font_hex ? 7'h77 : 7'h40;  // A / dash
      4'hb: segs = font_hex ? 7'h7c : 7'h79;  // b / E
      4'hc: segs = font_hex ? 7'h39 : 7'h76;  // C / H
      4'hd: segs = font_hex ? 7'h5e : 7'h38;  // d / L
      4'he: segs = font_hex ? 7'h79 : 7'h73;  // E / P
      4'hf: segs = font_hex ? 7'h71 : 7'h00;  // F / blank
      default: segs = 7'h00;
    endcase
  end

endmodule : ledhp_seg_decode

// ===== test/ledhp_host_model.sv
// host bus model: drives the write port of the led display block
`timescale 1ns/10ps
module ledhp_host_model (
  // clock
  input  wire logic             sys_clk,
  // host pins
  output ledhp_pkg::ledhp_host_t host
);
  import ledhp_pkg::*;
  // ==========================================================================
  // one write: address bit 0 picks the location, strobe low then rising
  task automatic bus_write(input logic [15:0] addr, input logic [7:0] data, input int slow);
    host.reg_sel = addr[0];
    host.data    = data;
    host.strobe  = 1'b0;
    repeat (3 + slow) @(negedge sys_clk);
    host.strobe  = 1'b1;
    // hold past the capture so the stored value is visible on return
    repeat (5 + slow) @(negedge sys_clk);
    // no pull on the lines: a released bus shows the inverse
    host.data    = ~data;
    host.digit_sel = host.digit_sel + 3'h1;
    // let one edge pass so the next call never drives the lines in this same time step
    @(negedge sys_clk);
  endtask : bus_write
  // idle bus: strobe high, nothing selected
  initial begin
    host = '{data: 8'h00, reg_sel: 1'b0, strobe: 1'b1, digit_sel: 3'h0};
  end
endmodule : ledhp_host_model

// ===== test/ledhp_top_props.sv
// checker: timing relations on the led display port pins
`timescale 1ns/10ps
module ledhp_top_props #(
  parameter int SCAN_COUNT = ledhp_pkg::SCAN_CYCLES
) (
  // clock and reset
  input wire logic                         SYS_CLK,
  input wire logic                         RST,
  // host pins
  input wire logic [ledhp_pkg::DATA_W-1:0] HOST_DATA,
  input wire logic                         REG_SEL,
  input wire logic                         WRITE_STROBE,
  // led lines
  input wire logic [ledhp_pkg::DIGITS-1:0] DIGIT_EN,
  input wire logic [ledhp_pkg::SEG_W-1:0]  SEG_OUT
);
  import ledhp_pkg::*;
  logic [DIGITS-1:0] en_q;
  logic [SEG_W-1:0]  seg_q;
  logic              stb_q;
  int                run_r;
  int                since_wr;
  logic              full_r;
  // ==========================================================================
  // run length of the shown digit and age of the last strobe edge
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      en_q     <= '0;
      seg_q    <= '0;
      stb_q    <= 1'b1;
      run_r    <= 0;
      since_wr <= 255;
      full_r   <= 1'b0;
    end else begin
      en_q     <= DIGIT_EN;
      seg_q    <= SEG_OUT;
      stb_q    <= WRITE_STROBE;
      run_r    <= (DIGIT_EN != en_q) ? 1 : run_r + 1;
      since_wr <= (WRITE_STROBE && !stb_q) ? 0 : (since_wr < 255 ? since_wr + 1 : 255);
      // a run is full only if it began at a scan step; blanking and wake-up leave short runs
      full_r   <= (DIGIT_EN == '0) ? 1'b0 : ((DIGIT_EN != en_q && en_q != '0) ? 1'b1 : full_r);
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // ==========================================================================
  // sequences of a control write and of the scan
  sequence s_cw_write;
    $rose(WRITE_STROBE) && REG_SEL;
  endsequence
  sequence s_dark;
    (DIGIT_EN == '0 && SEG_OUT == '0) [*2];
  endsequence
  sequence s_step;
    DIGIT_EN != en_q && en_q != '0 && DIGIT_EN != '0;
  endsequence
  a_one_digit: assert property ($onehot0(DIGIT_EN))
    else $error("more than one digit line driven");
  a_scan_order: assert property (s_step |-> DIGIT_EN == {en_q[DIGITS-2:0], en_q[DIGITS-1]})
    else $error("scan skipped a digit");
  a_scan_dwell: assert property (s_step ##0 full_r |-> run_r == SCAN_COUNT)
    else $error("digit dwell length wrong");
  a_blank_segs: assert property (DIGIT_EN == '0 |-> SEG_OUT == '0)
    else $error("segments lit with no digit");
  a_seg_cause: assert property (SEG_OUT != seg_q && DIGIT_EN == en_q && DIGIT_EN != '0 |-> since_wr <= 8)
    else $error("segments changed without a write");
  a_shutdown_dark: assert property (s_cw_write ##0 !HOST_DATA[CW_POWER] |-> ##6 s_dark)
    else $error("display not dark after power off");
  a_power_wake: assert property (s_cw_write ##0 HOST_DATA[CW_POWER] && !HOST_DATA[CW_BURST] |-> ##6 DIGIT_EN != '0)
    else $error("display dark after power on");
  a_burst_blank: assert property (s_cw_write ##0 HOST_DATA[CW_BURST] |-> ##6 DIGIT_EN == '0)
    else $error("display not blanked for burst");
endmodule : ledhp_top_props
bind ledhp_top ledhp_top_props #(.SCAN_COUNT(SCAN_COUNT)) ledhp_top_props_i (.SYS_CLK(SYS_CLK), .RST(RST),
  .HOST_DATA(HOST_DATA), .REG_SEL(REG_SEL), .WRITE_STROBE(WRITE_STROBE), .DIGIT_EN(DIGIT_EN), .SEG_OUT(SEG_OUT));

// ===== test/ledhp_top_tb.sv
// testbench: host writes through the bus model, scoreboard on the scanned outputs
`timescale 1ns/10ps
module ledhp_top_tb;
  import ledhp_pkg::*;
  localparam int SCAN  = 4;
  localparam int LIMIT = 30000;
  // ==========================================================================
  // fonts, segments a..g in bits 0..6
  localparam logic [6:0] HEX [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
                                      7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};
  localparam logic [6:0] BCD [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
                                      7'h7f, 7'h6f, 7'h40, 7'h79, 7'h76, 7'h38, 7'h73, 7'h00};
  localparam logic [3:0] CODE_A [8] = '{4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf, 4'h1, 4'h3};
  localparam logic [3:0] CODE_B [8] = '{4'h0, 4'h2, 4'h4, 4'h5, 4'h8, 4'ha, 4'hc, 4'hf};
  typedef struct packed {
    logic [2:0] dig;
    logic [7:0] seg;
  } ledhp_note_t;
  logic              sys_clk;
  logic              rst;
  ledhp_host_t       host;
  logic [DIGITS-1:0] digit_en;
  logic [SEG_W-1:0]  seg_out;
  ledhp_note_t       notes [$];
  int                fail_count;
  int                total_checks;
  int                cycles;
  logic [31:0]       rng;
  logic [7:0]        raw_b [8];
  logic              dp_a [8];
  logic              dp_b [8];
  // scan shortened to a few cycles per digit to keep the run brief
  ledhp_top #(.DIRECT_VARIANT(1'b0), .SCAN_COUNT(SCAN)) ledhp_top_i (.SYS_CLK(sys_clk), .RST(rst),
    .HOST_DATA(host.data), .REG_SEL(host.reg_sel), .WRITE_STROBE(host.strobe), .DIGIT_SEL(host.digit_sel),
    .FUNCTION_PIN(LEDHP_FN_HIGH), .DIGIT_EN(digit_en), .SEG_OUT(seg_out));
  ledhp_host_model ledhp_host_model_i (.sys_clk(sys_clk), .host(host));
  // ==========================================================================
  // helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    total_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask : check
  function automatic logic [7:0] rand8();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction : rand8
  function automatic logic [7:0] dec(input logic [3:0] code, input logic hex, input logic dp);
    return {dp, hex ? HEX[code] : BCD[code]};
  endfunction : dec
  // raw byte order is d f g e c b a dp, the point lights on a low bit
  function automatic logic [7:0] raw(input logic [7:0] r);
    return {~r[7], r[2], r[1], r[3], r[0], r[4], r[5], r[6]};
  endfunction : raw
  task automatic wr(input logic [15:0] a, input logic [7:0] v, input int s);
    ledhp_host_model_i.bus_write(a, v, s);
  endtask : wr
  // note one digit and wait until the watcher has taken it
  task automatic expect_digit(input int d, input logic [7:0] seg);
    notes.push_back('{dig: d[2:0], seg: seg});
    while (notes.size() != 0) @(negedge sys_clk);
  endtask : expect_digit
  task automatic expect_bank(input logic use_a, input logic hex);
    for (int d = 0; d < 8; d++) begin
      expect_digit(d, dec(use_a ? CODE_A[d] : CODE_B[d], hex, use_a ? dp_a[d] : dp_b[d]));
    end
  endtask : expect_bank
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  // ==========================================================================
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // watcher: compares the oldest note once its digit is on, and cuts a hang
  always @(negedge sys_clk) begin
    cycles++;
    if (notes.size() != 0 && digit_en === (8'h01 << notes[0].dig)) begin
      check(seg_out, notes[0].seg);
      void'(notes.pop_front());
    end
    if (cycles == LIMIT) begin
      fail_count++;
      give_verdict();
    end
  end
  // main sequence
  initial begin
    rst = 1'b1;
    fail_count = 0;
    total_checks = 0;
    cycles = 0;
    rng = 32'h0000_0031;
    repeat (3) @(negedge sys_clk);
    check(digit_en, 8'h00);
    rst = 1'b0;
    // display data before any control word is dropped
    wr(16'h0000, 8'h0c, 0);
    expect_digit(0, dec(4'h0, 1'b0, 1'b0));
    // raw mode, one addressed digit per control word, fast and slow host
    for (int d = 0; d < 8; d++) begin
      raw_b[d] = rand8();
      wr(16'h0001, 8'h30 | d[7:0], d % 2);
      wr(16'h0000, raw_b[d], 0);
      expect_digit(d, raw(raw_b[d]));
    end
    // a bare control word keeps every stored byte
    wr(16'h0001, 8'h35, 0);
    for (int d = 0; d < 8; d++) expect_digit(d, raw(raw_b[d]));
    // burst into bank a with hex font, then a ninth write that must be ignored
    wr(16'h0001, 8'hd8, 0);
    for (int d = 0; d < 8; d++) begin
      dp_a[d] = d[0];
      wr(16'h0000, {~dp_a[d], 3'h0, CODE_A[d]}, 0);
    end
    wr(16'h0000, 8'h00, 0);
    expect_bank(1'b1, 1'b1);
    // burst into bank b with the alternate font; points follow the last write
    wr(16'h0001, 8'h90, 0);
    for (int d = 0; d < 8; d++) begin
      dp_b[d] = d[1];
      dp_a[d] = d[1];
      wr(16'h0000, {~dp_b[d], 3'h0, CODE_B[d]}, 1);
    end
    expect_bank(1'b0, 1'b0);
    // switch banks and fonts with bare control words
    wr(16'h0001, 8'h58, 0);
    expect_bank(1'b1, 1'b1);
    wr(16'h0001, 8'h50, 0);
    expect_bank(1'b0, 1'b1);
    // power off holds the display dark, power on brings bank a back
    wr(16'h0001, 8'h00, 0);
    repeat (9 * SCAN) @(negedge sys_clk);
    check(digit_en, 8'h00);
    check(seg_out, 8'h00);
    wr(16'h0001, 8'h18, 0);
    expect_bank(1'b1, 1'b0);
    give_verdict();
  end
endmodule : ledhp_top_tb
